// File: inc/bpc_defines.vh
// Register map, field positions, state codes and setting encodings of the burner process FSM
`ifndef BPC_DEFINES_VH
`define BPC_DEFINES_VH

`define BPC_ADDR_W        12
`define BPC_OFF_CTRL      12'h000
`define BPC_OFF_COND      12'h004
`define BPC_OFF_STATE     12'h008
`define BPC_OFF_IRQ_STAT  12'h00c
`define BPC_OFF_IRQ_MASK  12'h010

// Control register fields
`define BPC_CTRL_POM_LSB  0
`define BPC_CTRL_LFD_BIT  2
`define BPC_CTRL_INC_BIT  3
`define BPC_CTRL_RST      32'h0000_0000

// Condition register fields
`define BPC_COND_ALARM    0
`define BPC_COND_WAIT     1
`define BPC_COND_PERM     2
`define BPC_COND_FLOSS    3
`define BPC_COND_RLEX     4
`define BPC_COND_STOP     5
`define BPC_COND_BPROC    6
`define BPC_COND_AWGON    7
`define BPC_COND_BAGOFF   8
`define BPC_COND_REIGN    9
`define BPC_COND_W        10

// Pilot-off settings
`define BPC_POM_DISABLED  2'h0
`define BPC_POM_AT_SP     2'h1
`define BPC_POM_AFTER_ON  2'h2
`define BPC_POM_FOLLOW    2'h3

// State codes
`define BPC_ST_IDLE       3'h0
`define BPC_ST_LOCKOUT    3'h1
`define BPC_ST_WAITING    3'h2
`define BPC_ST_PILOT      3'h3
`define BPC_ST_LOWFIRE    3'h4
`define BPC_ST_HIGHFIRE   3'h5
`define BPC_ST_INCIN      3'h6
`define BPC_ST_INCNA      3'h7

// Interrupt status bits
`define BPC_IRQ_LOCKOUT   0
`define BPC_IRQ_WAITING   1
`define BPC_IRQ_CHANGE    2
`define BPC_IRQ_W         3

`endif

// File: design/bpc_fsm.v
// Burner process-control state machine (High Fire, Incinerate) with APB registers
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "bpc_defines.vh"

module bpc_fsm (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        alarm_in,
  input  wire        wait_in,
  input  wire        main_perm_in,
  input  wire        flame_loss_in,
  input  wire        relight_exceeded_in,
  input  wire        user_stop_in,
  input  wire        below_process_sp_in,
  input  wire        above_waste_gas_on_in,
  input  wire        below_assist_off_in,
  input  wire        reignite_in,
  input  wire        ext_state_valid_in,
  input  wire [2:0]  ext_state_in,
  output reg  [2:0]  state_out,
  output reg         pilot_out,
  output reg         first_shutoff_valve,
  output reg         second_shutoff_valve,
  output reg         pilot_card_valve,
  output reg         ignition_coil,
  output reg         ignition_enable,
  output reg         irq
);

  localparam [2:0] ST_IDLE    = `BPC_ST_IDLE;
  localparam [2:0] ST_LOCKOUT = `BPC_ST_LOCKOUT;
  localparam [2:0] ST_WAITING = `BPC_ST_WAITING;
  localparam [2:0] ST_PILOT   = `BPC_ST_PILOT;
  localparam [2:0] ST_LOWFIRE = `BPC_ST_LOWFIRE;
  localparam [2:0] ST_HIGH    = `BPC_ST_HIGHFIRE;
  localparam [2:0] ST_INCIN   = `BPC_ST_INCIN;
  localparam [2:0] ST_INCNA   = `BPC_ST_INCNA;

  // Two-flop synchronisers for the external condition inputs
  wire [`BPC_COND_W-1:0] cond_raw;
  reg  [`BPC_COND_W-1:0] cond_meta_q;
  reg  [`BPC_COND_W-1:0] cond_q;
  reg                    ext_v_meta_q;
  reg                    ext_v_q;
  reg  [2:0]             ext_st_meta_q;
  reg  [2:0]             ext_st_q;
  reg  [2:0]             ext_st_hold_q;
  wire                   ext_ok;

  assign cond_raw = {reignite_in, below_assist_off_in, above_waste_gas_on_in,
                     below_process_sp_in, user_stop_in, relight_exceeded_in,
                     flame_loss_in, main_perm_in, wait_in, alarm_in};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_meta_q   <= {`BPC_COND_W{1'b0}};
      cond_q        <= {`BPC_COND_W{1'b0}};
      ext_v_meta_q  <= 1'b0;
      ext_v_q       <= 1'b0;
      ext_st_meta_q <= 3'h0;
      ext_st_q      <= 3'h0;
      ext_st_hold_q <= 3'h0;
    end else begin
      cond_meta_q   <= cond_raw;
      cond_q        <= cond_meta_q;
      ext_v_meta_q  <= ext_state_valid_in;
      ext_v_q       <= ext_v_meta_q;
      ext_st_meta_q <= ext_state_in;
      ext_st_q      <= ext_st_meta_q;
      ext_st_hold_q <= ext_st_q;
    end
  end

  // The state word crosses bit by bit: act on it only once it has stood two samples,
  // and never let another block command a firing state past the local guards
  assign ext_ok = ext_v_q && (ext_st_q == ext_st_hold_q) &&
                  (ext_st_q != `BPC_ST_HIGHFIRE) && (ext_st_q != `BPC_ST_INCIN);

  wire c_alarm  = cond_q[`BPC_COND_ALARM];
  wire c_wait   = cond_q[`BPC_COND_WAIT];
  wire c_perm   = cond_q[`BPC_COND_PERM];
  wire c_floss  = cond_q[`BPC_COND_FLOSS];
  wire c_rlex   = cond_q[`BPC_COND_RLEX];
  wire c_stop   = cond_q[`BPC_COND_STOP];
  wire c_bproc  = cond_q[`BPC_COND_BPROC];
  wire c_awgon  = cond_q[`BPC_COND_AWGON];
  wire c_bagoff = cond_q[`BPC_COND_BAGOFF];
  wire c_reign  = cond_q[`BPC_COND_REIGN];

  // Software-held configuration, interrupt status and the state register
  reg  [31:0] ctrl_q;
  reg  [`BPC_IRQ_W-1:0] irq_stat_q;
  reg  [`BPC_IRQ_W-1:0] irq_mask_q;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;

  wire [1:0] pom      = ctrl_q[`BPC_CTRL_POM_LSB+1:`BPC_CTRL_POM_LSB];
  wire       lf_dis   = ctrl_q[`BPC_CTRL_LFD_BIT];
  wire       inc_en   = ctrl_q[`BPC_CTRL_INC_BIT];
  wire       pom_wait = (pom == `BPC_POM_AFTER_ON) || (pom == `BPC_POM_FOLLOW);
  wire       clear_go = !c_alarm && !c_wait && !c_perm;
  wire       to_lock  = c_alarm || c_stop || (c_floss && c_rlex);
  wire       to_wait  = c_wait || (c_floss && !c_rlex) || (c_perm && pom_wait);

  // Next-state logic, one evaluation per clock
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_HIGH: begin
        if (to_lock) begin
          state_d = ST_LOCKOUT;
        end else if (to_wait) begin
          state_d = ST_WAITING;
        end else if (c_perm) begin
          state_d = ST_PILOT;
        end else if (!c_bproc && lf_dis) begin
          state_d = pom_wait ? ST_WAITING : ST_PILOT;
        end else if (!c_bproc) begin
          state_d = ST_LOWFIRE;
        end
      end
      ST_INCIN: begin
        if (to_lock) begin
          state_d = ST_LOCKOUT;
        end else if (to_wait) begin
          state_d = ST_WAITING;
        end else if (c_perm) begin
          state_d = ST_PILOT;
        end else if (!c_awgon && inc_en && clear_go) begin
          state_d = ST_LOWFIRE;
        end else if (!c_bagoff && clear_go) begin
          state_d = ST_INCNA;
        end
      end
      ST_PILOT: begin
        if (c_bproc && lf_dis && clear_go) begin
          state_d = ST_HIGH;
        end else if (ext_ok) begin
          state_d = ext_st_q;
        end
      end
      ST_LOWFIRE: begin
        if (c_bproc && clear_go) begin
          state_d = ST_HIGH;
        end else if (c_awgon && inc_en && clear_go) begin
          state_d = ST_INCIN;
        end else if (ext_ok) begin
          state_d = ext_st_q;
        end
      end
      ST_INCNA: begin
        if (c_bagoff && clear_go) begin
          state_d = ST_INCIN;
        end else if (ext_ok) begin
          state_d = ext_st_q;
        end
      end
      ST_IDLE, ST_LOCKOUT, ST_WAITING: begin
        if (ext_ok) begin
          state_d = ext_st_q;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  wire in_proc   = (state_d == ST_HIGH) || (state_d == ST_INCIN);
  wire pilot_on  = in_proc && (pom != `BPC_POM_AFTER_ON);
  wire ign_on    = in_proc && c_reign;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q              <= ST_IDLE;
      state_out            <= ST_IDLE;
      pilot_out            <= 1'b0;
      first_shutoff_valve  <= 1'b0;
      second_shutoff_valve <= 1'b0;
      pilot_card_valve     <= 1'b0;
      ignition_coil        <= 1'b0;
      ignition_enable      <= 1'b0;
    end else begin
      state_q              <= state_d;
      state_out            <= state_d;
      pilot_out            <= pilot_on;
      first_shutoff_valve  <= in_proc;
      second_shutoff_valve <= in_proc;
      pilot_card_valve     <= pilot_on;
      ignition_coil        <= ign_on;
      ignition_enable      <= ign_on;
    end
  end

  // APB slave: zero wait states, unmapped addresses error
  wire        acc     = psel && penable;
  wire        wr      = acc && pwrite;
  wire [11:0] addr    = paddr[11:0];
  wire        mapped  = (paddr[31:12] == 20'h0_0000) &&
                        ((addr == `BPC_OFF_CTRL) || (addr == `BPC_OFF_COND) ||
                         (addr == `BPC_OFF_STATE) || (addr == `BPC_OFF_IRQ_STAT) ||
                         (addr == `BPC_OFF_IRQ_MASK));
  wire [`BPC_IRQ_W-1:0] ev;
  wire [`BPC_IRQ_W-1:0] w1c;

  assign ev[`BPC_IRQ_LOCKOUT] = (state_d == ST_LOCKOUT) && (state_q != ST_LOCKOUT);
  assign ev[`BPC_IRQ_WAITING] = (state_d == ST_WAITING) && (state_q != ST_WAITING);
  assign ev[`BPC_IRQ_CHANGE]  = (state_d != state_q);
  assign w1c = (wr && (addr == `BPC_OFF_IRQ_STAT) && mapped) ?
               pwdata[`BPC_IRQ_W-1:0] : {`BPC_IRQ_W{1'b0}};

  reg [31:0] rdata_d;
  always @* begin
    rdata_d = 32'h0000_0000;
    case (addr)
      `BPC_OFF_CTRL:     rdata_d = {28'h000_0000, ctrl_q[3:0]};
      `BPC_OFF_COND:     rdata_d = {22'h00_0000, cond_q};
      `BPC_OFF_STATE:    rdata_d = {29'h0000_0000, state_q};
      `BPC_OFF_IRQ_STAT: rdata_d = {29'h0000_0000, irq_stat_q};
      `BPC_OFF_IRQ_MASK: rdata_d = {29'h0000_0000, irq_mask_q};
      default:           rdata_d = 32'h0000_0000;
    endcase
    if (!mapped) begin
      rdata_d = 32'h0000_0000;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= `BPC_CTRL_RST;
      irq_stat_q <= {`BPC_IRQ_W{1'b0}};
      irq_mask_q <= {`BPC_IRQ_W{1'b0}};
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      irq        <= 1'b0;
    end else begin
      if (wr && mapped && (addr == `BPC_OFF_CTRL)) begin
        ctrl_q <= {28'h000_0000, pwdata[3:0]};
      end
      if (wr && mapped && (addr == `BPC_OFF_IRQ_MASK)) begin
        irq_mask_q <= pwdata[`BPC_IRQ_W-1:0];
      end
      // Set wins over a simultaneous write-one-to-clear
      irq_stat_q <= (irq_stat_q & ~w1c) | ev;
      irq        <= |(((irq_stat_q & ~w1c) | ev) & irq_mask_q);
      pready     <= psel && !penable;
      pslverr    <= psel && !penable && !mapped;
      prdata     <= (psel && !penable && !pwrite) ? rdata_d : 32'h0000_0000;
    end
  end

endmodule // bpc_fsm

`default_nettype wire

// File: bench/bpc_fsm_properties.sv
// Port assertions for the burner process state machine
`timescale 1ns/1ps
`default_nettype none
module bpc_fsm_props (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       alarm_in,
  input wire logic       wait_in,
  input wire logic       main_perm_in,
  input wire logic       flame_loss_in,
  input wire logic       user_stop_in,
  input wire logic       below_process_sp_in,
  input wire logic       above_waste_gas_on_in,
  input wire logic       below_assist_off_in,
  input wire logic [2:0] state_out,
  input wire logic       pilot_out,
  input wire logic       first_shutoff_valve,
  input wire logic       second_shutoff_valve,
  input wire logic       pilot_card_valve,
  input wire logic       ignition_coil,
  input wire logic       ignition_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire fire = state_out == 3'h5 || state_out == 3'h6;
  wire halt = alarm_in || user_stop_in;
  wire calm = !halt && !wait_in && !main_perm_in && !flame_loss_in;
  wire waitc = !halt && !flame_loss_in && wait_in;
  wire rise = calm && !below_process_sp_in;
  wire asoff = calm && above_waste_gas_on_in && !below_assist_off_in;
  wire ason = calm && below_assist_off_in;
  wire any_on = pilot_out || first_shutoff_valve || second_shutoff_valve || ignition_coil;
  // Two sync flops: a level must stand three samples to decide the next state
  sequence held_s(c);
    c [*3];
  endsequence
  valves_on_a: assert property (fire |-> first_shutoff_valve && second_shutoff_valve)
    else $error("shutoff valve off while firing");
  safe_off_a: assert property (!fire |-> !any_on)
    else $error("output on outside firing states");
  pair_a: assert property (ignition_coil == ignition_enable && pilot_out == pilot_card_valve)
    else $error("paired outputs disagree");
  lockout_go_a: assert property (held_s(halt) ##0 fire |=> state_out == 3'h1)
    else $error("no lockout");
  wait_go_a: assert property (held_s(waitc) ##0 fire |=> state_out == 3'h2)
    else $error("no waiting");
  hf_leave_a: assert property (held_s(rise) ##0 state_out == 3'h5 |=>
    state_out inside {3'h2, 3'h3, 3'h4})
    else $error("high fire kept above setpoint");
  assist_off_a: assert property (held_s(asoff) ##0 state_out == 3'h6 |=> state_out == 3'h7)
    else $error("no move to no assist");
  assist_on_a: assert property (held_s(ason) ##0 state_out == 3'h7 |=> state_out == 3'h6)
    else $error("no return to incinerate");
endmodule // bpc_fsm_props
`default_nettype wire

// File: bench/bpc_plant.sv
// Sensor stand-in: condition levels reach the controller one clock after being set
`timescale 1ns/1ps
`default_nettype none
module bpc_plant (
  input  wire logic       pclk,
  input  wire logic [9:0] cond_req,
  output var  logic [9:0] sense
);
  initial sense = 10'h000;
  always @(posedge pclk) begin
    sense <= cond_req;
  end
endmodule // bpc_plant
`default_nettype wire

// File: bench/bpc_fsm_tb.sv
// Self-checking bench for the burner process state machine
`timescale 1ns/1ps
`default_nettype none
module bpc_fsm_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, irq, rerr, ext_v = 1'b0;
  logic [9:0]  cond = 10'h000, sense;
  logic [2:0]  ext_s = 3'h0, state_out;
  logic [5:0]  outs;
  int          comparisons = 0, miscompares = 0, cycles = 0;
  // Exits from High Fire: condition levels, pilot-off setting, next state
  logic [9:0]  xc [10] = '{10'h003, 10'h020, 10'h018, 10'h002, 10'h008,
                           10'h004, 10'h004, 10'h004, 10'h004, 10'h006};
  logic [1:0]  xp [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h3, 2'h0, 2'h1, 2'h1};
  logic [2:0]  xs [10] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h2};
  bpc_fsm bpc_fsm_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .alarm_in(sense[0]), .wait_in(sense[1]), .main_perm_in(sense[2]),
    .flame_loss_in(sense[3]), .relight_exceeded_in(sense[4]), .user_stop_in(sense[5]),
    .below_process_sp_in(sense[6]), .above_waste_gas_on_in(sense[7]),
    .below_assist_off_in(sense[8]), .reignite_in(sense[9]), .ext_state_valid_in(ext_v),
    .ext_state_in(ext_s), .state_out, .pilot_out(outs[5]), .first_shutoff_valve(outs[4]),
    .second_shutoff_valve(outs[3]), .pilot_card_valve(outs[2]), .ignition_coil(outs[1]),
    .ignition_enable(outs[0]), .irq);
  bpc_plant bpc_plant_inst (.pclk, .cond_req(cond), .sense);
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic to(input logic [2:0] s);
    repeat (30) if (state_out !== s) @(negedge pclk);
    chk(32'(state_out), 32'(s));
  endtask
  task automatic step(input logic [9:0] c, input logic [2:0] s);
    @(posedge pclk);
    cond <= c;
    to(s);
  endtask
  task automatic place(input logic [2:0] s);
    @(posedge pclk);
    ext_v <= 1'b1;
    ext_s <= s;
    step(10'h000, s);
    @(posedge pclk);
    ext_v <= 1'b0;
  endtask
  task automatic t_reset;
    chk(32'(state_out), 32'h0);
    chk(32'(outs), 32'h0);
    apb(1'b0, 32'h0, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, 32'h20, 32'h0);
    chk({rdat[30:0], rerr}, 32'h1);
  endtask
  task automatic t_high;
    apb(1'b1, 32'h0, 32'h4);
    place(3'h3);
    step(10'h040, 3'h5);
    repeat (5) @(negedge pclk);
    chk(32'(outs), 32'h3c);
    step(10'h240, 3'h5);
    repeat (5) @(negedge pclk);
    chk(32'(outs), 32'h3f);
    apb(1'b1, 32'h0, 32'h6);
    repeat (5) @(negedge pclk);
    chk(32'(outs), 32'h1b);
    step(10'h000, 3'h2);
    apb(1'b1, 32'h0, 32'h5);
    place(3'h3);
    step(10'h040, 3'h5);
    step(10'h000, 3'h3);
  endtask
  task automatic t_incin;
    apb(1'b1, 32'h0, 32'h8);
    place(3'h4);
    step(10'h040, 3'h5);
    step(10'h000, 3'h4);
    step(10'h180, 3'h6);
    repeat (5) @(negedge pclk);
    chk(32'(outs), 32'h3c);
    step(10'h080, 3'h7);
    step(10'h180, 3'h6);
    step(10'h100, 3'h4);
  endtask
  task automatic t_exits;
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, 32'h0, {29'h0, 1'b1, xp[i]});
      place(3'h3);
      step(10'h040, 3'h5);
      step(xc[i] | 10'h040, xs[i]);
    end
  endtask
  task automatic t_irq;
    apb(1'b1, 32'h10, 32'h1);
    place(3'h3);
    step(10'h040, 3'h5);
    apb(1'b1, 32'hc, 32'h7);
    repeat (2) @(negedge pclk);
    chk(32'(irq), 32'h0);
    step(10'h041, 3'h1);
    chk(32'(irq), 32'h1);
    apb(1'b0, 32'hc, 32'h0);
    chk(rdat, 32'h5);
    apb(1'b1, 32'h10, 32'h0);
    repeat (2) @(negedge pclk);
    chk(32'(irq), 32'h0);
    apb(1'b1, 32'h10, 32'h1);
    repeat (2) @(negedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b1, 32'hc, 32'h1);
    repeat (2) @(negedge pclk);
    chk(32'(irq), 32'h0);
  endtask
  task automatic conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_reset();
    t_high();
    t_incin();
    t_exits();
    t_irq();
    conclude();
  end
endmodule // bpc_fsm_tb
bind bpc_fsm bpc_fsm_props bpc_fsm_props_inst (
  .pclk, .presetn, .alarm_in, .wait_in, .main_perm_in, .flame_loss_in, .user_stop_in,
  .below_process_sp_in, .above_waste_gas_on_in, .below_assist_off_in, .state_out,
  .pilot_out, .first_shutoff_valve, .second_shutoff_valve, .pilot_card_valve,
  .ignition_coil, .ignition_enable);
`default_nettype wire
